// [dv/rtcm_top_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module rtcm_top_tb import rtcm_pkg::*; ;
    localparam int CONV = 8;
    // stimulus
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    rtcm_time_s now = {8'h01, 8'h01, 8'h01, 8'h01, 8'h55, 8'h00};
    logic one_sec_tick = 1'b0;
    logic battery_mode_pin = 1'b0;
    logic vbat_low_pin = 1'b0;
    logic [9:0] temp_sample = 10'h12C;
    logic [5:0] comp_coarse = 6'h2A;
    logic [4:0] comp_fine = 5'h13;
    logic freq_wave = 1'b0;
    // observed
    logic [7:0] reg_rdata;
    logic sense_active;
    logic [9:0] temp_result;
    logic [4:0] beta_active;
    logic [5:0] coarse_trim_setting;
    logic [4:0] fine_trim_setting;
    logic irq_pin_o;
    logic irq_pin_oe;
    int n_errors = 0;
    int n_compared = 0;
    int n;

    rtcm_top #(.CONV_CYCLES(CONV)) u_dut (
        .clock(clock), .sys_rst(sys_rst),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .now(now), .one_sec_tick(one_sec_tick),
        .battery_mode_pin(battery_mode_pin), .vbat_low_pin(vbat_low_pin),
        .temp_sample(temp_sample), .comp_coarse(comp_coarse),
        .comp_fine(comp_fine), .sense_active(sense_active),
        .temp_result(temp_result), .beta_active(beta_active),
        .coarse_trim_setting(coarse_trim_setting),
        .fine_trim_setting(fine_trim_setting),
        .freq_wave(freq_wave), .irq_pin_o(irq_pin_o),
        .irq_pin_oe(irq_pin_oe)
    );

    always #2 clock = ~clock;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic summarize;
        $display("errors=%0d compared=%0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic cyc(input int k);
        repeat (k) @(posedge clock);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask

    // read one byte and compare it
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clock);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1;
        check(reg_rdata, exp);
    endtask

    // seconds ticks until a sensing cycle shows, 0 if none
    task automatic tick_until(input int max, output int k);
        k = 0;
        for (int i = 1; i <= max && k == 0; i++) begin
            @(posedge clock);
            one_sec_tick <= 1'b1;
            @(posedge clock);
            one_sec_tick <= 1'b0;
            repeat (3) @(posedge clock);
            #1;
            if (sense_active === 1'b1) k = i;
        end
    endtask

    task automatic wait_done(output int k);
        k = 0;
        while (sense_active !== 1'b0 && k < 500) begin
            @(posedge clock);
            #1;
            k++;
        end
    endtask

    // step seconds off and back onto 30, count pin-low cycles
    task automatic match(output int k);
        k = 0;
        @(posedge clock);
        now.sec <= 8'h31;
        cyc(2);
        now.sec <= 8'h30;
        repeat (12) begin
            @(posedge clock);
            #1;
            if (irq_pin_oe === 1'b1) k++;
        end
    endtask

    initial begin
        #200000;
        n_errors++;
        $display("watchdog expired at t=%0t", $time);
        summarize();
    end

    initial begin
        repeat (5) @(posedge clock);
        sys_rst <= 1'b0;
        @(posedge clock);
        #1;
        check(irq_pin_oe, 1'b0);
        check(beta_active, BETA_PRESET);
        check(coarse_trim_setting, INIT_COARSE_RST);
        rdc(ADDR_BETA, {3'b000, BETA_PRESET});
        rdc(ADDR_FINAL_COARSE, {2'b00, INIT_COARSE_RST});
        wr(ADDR_FINAL_COARSE, 8'hFF);
        wr(ADDR_FINAL_FINE, 8'hFF);
        rdc(ADDR_FINAL_COARSE, {2'b00, INIT_COARSE_RST});
        rdc(ADDR_FINAL_FINE, {3'b000, INIT_FINE_RST});
        rdc(8'h30, 8'h00);
        for (int i = 0; i < 6; i++) begin
            rdc(ADDR_ALARM_FIRST + 8'(i), ALARM_RST);
        end
        // sensing off: initial trims drive the monitors
        wr(ADDR_INIT_COARSE, 8'h15);
        wr(ADDR_INIT_FINE, 8'h0A);
        cyc(2);
        rdc(ADDR_FINAL_COARSE, 8'h15);
        rdc(ADDR_FINAL_FINE, 8'h0A);
        // gain factor in two writes, then one conversion cycle
        wr(ADDR_BETA, 8'h1F);
        wr(ADDR_BETA, 8'h9F);
        cyc(2);
        #1;
        check(sense_active, 1'b1);
        check(beta_active, 5'h1F);
        wait_done(n);
        check(n inside {[2*CONV-4:2*CONV+4]}, 1'b1);
        check(temp_result, 10'h12C);
        rdc(ADDR_FINAL_COARSE, 8'h2A);
        rdc(ADDR_FINAL_FINE, 8'h13);
        // battery mode periods
        @(posedge clock);
        battery_mode_pin <= 1'b1;
        wr(ADDR_BETA, 8'hBF);
        tick_until(70, n);
        check(n, 0);
        wr(ADDR_BETA, 8'hFF);
        tick_until(100, n);
        check(n, 60);
        wait_done(n);
        wr(ADDR_BETA, 8'hDF);
        tick_until(700, n);
        check(n, 600);
        wait_done(n);
        @(posedge clock);
        vbat_low_pin <= 1'b1;
        wr(ADDR_BETA, 8'hFF);
        tick_until(70, n);
        check(n, 0);
        @(posedge clock);
        battery_mode_pin <= 1'b0;
        vbat_low_pin <= 1'b0;
        // alarm on seconds only, single mode
        wr(ADDR_INT_CTRL, 8'h00);
        wr(ADDR_STATUS, 8'h00);
        for (int i = 1; i < 6; i++) wr(ADDR_ALARM_FIRST + 8'(i), 8'h00);
        wr(ADDR_ALARM_FIRST, 8'hB0);
        rdc(ADDR_ALARM_FIRST, 8'hB0);
        match(n);
        check(n, 11);
        check(irq_pin_o, 1'b0);
        rdc(ADDR_STATUS, 8'h40);
        wr(ADDR_STATUS, 8'h40);
        cyc(3);
        #1;
        check(irq_pin_oe, 1'b1);
        wr(ADDR_STATUS, 8'h00);
        cyc(3);
        #1;
        check(irq_pin_oe, 1'b0);
        cyc(10);
        #1;
        check(irq_pin_oe, 1'b0);
        // clear by reading status
        wr(ADDR_STATUS, 8'h80);
        match(n);
        rdc(ADDR_STATUS, 8'hC0);
        rdc(ADDR_STATUS, 8'h80);
        cyc(3);
        #1;
        check(irq_pin_oe, 1'b0);
        // repeating pulses
        wr(ADDR_INT_CTRL, 8'h80);
        wr(ADDR_STATUS, 8'h00);
        match(n);
        check(n, 4);
        match(n);
        check(n, 4);
        // minutes joins the compare
        wr(ADDR_ALARM_FIRST + 8'h01, 8'h95);
        match(n);
        check(n, 0);
        @(posedge clock);
        now.sec <= 8'h31;
        now.min <= 8'h15;
        match(n);
        check(n, 4);
        // frequency output takes the pin over
        wr(ADDR_INT_CTRL, 8'h01);
        freq_wave <= 1'b1;
        cyc(3);
        #1;
        check(irq_pin_oe, 1'b0);
        @(posedge clock);
        freq_wave <= 1'b0;
        cyc(3);
        #1;
        check(irq_pin_oe, 1'b1);
        summarize();
    end
endmodule
`default_nettype wire

// [src/rtcm_alarm_cmp.sv]
`timescale 1ns/1ps
`default_nettype none
module rtcm_alarm_cmp import rtcm_pkg::*; (
    // clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // running time and alarm bytes
    input wire rtcm_time_s now,
    input wire logic [ALARM_FIELDS-1:0][7:0] alarm,
    // match event
    output logic hit
);
    logic [ALARM_FIELDS-1:0] field_ok;
    logic [ALARM_FIELDS-1:0] field_en;
    logic [8*ALARM_FIELDS-1:0] now_bits;
    logic match;
    logic match_r;

    assign now_bits = now;

    genvar i;
    generate
        for (i = 0; i < ALARM_FIELDS; i++) begin : g_field
            assign field_en[i] = alarm[i][ALARM_EN_BIT];
            assign field_ok[i] = !field_en[i] ||
                (alarm[i][6:0] == now_bits[8*i +: 7]);
        end
    endgenerate

    assign match = (&field_ok) && (|field_en);

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            match_r <= 1'b0;
        end else begin
            match_r <= match;
        end
    end

    // time advancing into the match, not lingering in it
    assign hit = match && !match_r;

    chk_hit_needs_enable: assert property (@(posedge clock) disable iff (sys_rst) hit |-> (|field_en) && !$past(match)) else $error("alarm hit without enabled field or edge");

endmodule
`default_nettype wire

// [src/rtcm_pkg.sv]
package rtcm_pkg;

    // register offsets
    localparam logic [7:0] ADDR_INT_CTRL = 8'h07;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_INIT_COARSE = 8'h09;
    localparam logic [7:0] ADDR_INIT_FINE = 8'h0A;
    localparam logic [7:0] ADDR_BETA = 8'h0D;
    localparam logic [7:0] ADDR_FINAL_COARSE = 8'h0E;
    localparam logic [7:0] ADDR_FINAL_FINE = 8'h0F;
    localparam logic [7:0] ADDR_ALARM_FIRST = 8'h10;
    localparam logic [7:0] ADDR_ALARM_LAST = 8'h15;
    localparam int ALARM_FIELDS = 6;

    // field positions
    localparam int STAT_AUTOCLR_BIT = 7;
    localparam int STAT_ALARM_BIT = 6;
    localparam int BETA_TSE_BIT = 7;
    localparam int BETA_BATTERY_SENSE_ENABLE_BIT = 6;
    localparam int BETA_BATTERY_SENSE_RATE_BIT = 5;
    localparam int CTRL_REPEAT_BIT = 7;
    localparam int ALARM_EN_BIT = 7;

    // values after reset, and gain factor bounds
    localparam logic [4:0] BETA_PRESET = 5'h10;
    localparam logic [4:0] BETA_MIN = 5'h08;
    localparam logic [4:0] BETA_MAX = 5'h1F;
    localparam logic [5:0] INIT_COARSE_RST = 6'h20;
    localparam logic [4:0] INIT_FINE_RST = 5'h00;
    localparam logic [7:0] ALARM_RST = 8'h01;

    // timing
    localparam logic [9:0] SLOW_PERIOD_S = 10'h258;
    localparam logic [9:0] FAST_PERIOD_S = 10'h03C;
    localparam int CONV_TIME_US = 22000;
    localparam int CLK_MHZ = 250;
    localparam int CONV_CYCLES_DEF = CONV_TIME_US * CLK_MHZ;
    localparam logic [3:0] IRQ_PULSE_CYCLES = 4'h4;

    typedef logic [7:0] rtcm_byte_t;

    // lowest byte is seconds, same order as the alarm bytes
    typedef struct packed {
        rtcm_byte_t wday;
        rtcm_byte_t month;
        rtcm_byte_t date;
        rtcm_byte_t hour;
        rtcm_byte_t min;
        rtcm_byte_t sec;
    } rtcm_time_s;

    typedef enum logic [1:0] {
        CONV_IDLE,
        CONV_FIRST,
        CONV_SECOND
    } rtcm_conv_e;

endpackage

// [src/rtcm_top.sv]
// Operation
// - battery sensing only when battery enable set
// - low battery blocks battery sensing
// - battery period ten minutes, or one minute
// - enable clear means no battery compensation
// - each conversion lasts about 22 ms
// - preset gain factor, software may override
// - new gain factor used from next cycle
// - coarse trim monitor read only, six bits
// - fine trim monitor read only, five bits
// - six alarm bytes, top bit enables field
// - only enabled alarm fields are compared
// - alarm triggers when time reaches match
// - single mode: flag set, pin held low
// - repeat mode: low pulse every match
// - writing zero clears flag, releases pin
// - auto clear flag on status read
// - sense enable starts two averaged conversions outside battery mode
// - sensing off uses initial trim values
`timescale 1ns/1ps
`default_nettype none
module rtcm_top import rtcm_pkg::*; #(
    parameter int CONV_CYCLES = CONV_CYCLES_DEF
) (
    // clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // register port
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // time base
    input wire rtcm_time_s now,
    input wire logic one_sec_tick,
    // supply status pins
    input wire logic battery_mode_pin,
    input wire logic vbat_low_pin,
    // sensor and compensation core
    input wire logic [9:0] temp_sample,
    input wire logic [5:0] comp_coarse,
    input wire logic [4:0] comp_fine,
    output logic sense_active,
    output logic [9:0] temp_result,
    output logic [4:0] beta_active,
    output logic [5:0] coarse_trim_setting,
    output logic [4:0] fine_trim_setting,
    // interrupt_or_freq_pin, open drain
    input wire logic freq_wave,
    output logic irq_pin_o,
    output logic irq_pin_oe
);
    logic tse_r, battery_sense_enable_r, battery_sense_rate_r, auto_clr_r, repeat_mode_r, alarm_flag_r;
    logic [4:0] beta_r;
    logic [3:0] freq_sel_r;
    logic [5:0] init_coarse_r, comp_coarse_r;
    logic [4:0] init_fine_r, comp_fine_r;
    logic [ALARM_FIELDS-1:0][7:0] alarm_r;
    logic batt_s1_r, batt_r, vlow_s1_r, vlow_r;
    rtcm_conv_e conv_state_r;
    logic [23:0] conv_cnt_r;
    logic [10:0] temp_sum_r;
    logic [9:0] sec_cnt_r;
    logic [3:0] pulse_cnt_r;
    logic [9:0] period_last;
    logic wr_beta, wr_status, rd_status, tse_start, batt_en, batt_due;
    logic conv_start, conv_end, alarm_hit, freq_on, pull_low, flag_clr;
    logic [11:0] temp_total;

    assign wr_beta = reg_wr && (reg_addr == ADDR_BETA);
    assign wr_status = reg_wr && (reg_addr == ADDR_STATUS);
    assign rd_status = reg_rd && (reg_addr == ADDR_STATUS);
    assign tse_start = wr_beta && reg_wdata[BETA_TSE_BIT] && !tse_r;

    // pins from outside the clock domain
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            batt_s1_r <= 1'b0;
            batt_r <= 1'b0;
            vlow_s1_r <= 1'b0;
            vlow_r <= 1'b0;
        end else begin
            batt_s1_r <= battery_mode_pin;
            batt_r <= batt_s1_r;
            vlow_s1_r <= vbat_low_pin;
            vlow_r <= vlow_s1_r;
        end
    end

    // writable registers
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            tse_r <= 1'b0;
            battery_sense_enable_r <= 1'b0;
            battery_sense_rate_r <= 1'b0;
            beta_r <= BETA_PRESET;
            auto_clr_r <= 1'b0;
            repeat_mode_r <= 1'b0;
            freq_sel_r <= 4'h0;
            init_coarse_r <= INIT_COARSE_RST;
            init_fine_r <= INIT_FINE_RST;
        end else if (reg_wr) begin
            case (reg_addr)
                ADDR_BETA: begin
                    tse_r <= reg_wdata[BETA_TSE_BIT];
                    battery_sense_enable_r <= reg_wdata[BETA_BATTERY_SENSE_ENABLE_BIT];
                    battery_sense_rate_r <= reg_wdata[BETA_BATTERY_SENSE_RATE_BIT];
                    beta_r <= reg_wdata[4:0];
                end
                ADDR_STATUS: auto_clr_r <= reg_wdata[STAT_AUTOCLR_BIT];
                ADDR_INT_CTRL: begin
                    repeat_mode_r <= reg_wdata[CTRL_REPEAT_BIT];
                    freq_sel_r <= reg_wdata[3:0];
                end
                ADDR_INIT_COARSE: init_coarse_r <= reg_wdata[5:0];
                ADDR_INIT_FINE: init_fine_r <= reg_wdata[4:0];
                default: ;
            endcase
        end
    end

    // alarm bytes
    genvar i;
    generate
        for (i = 0; i < ALARM_FIELDS; i++) begin : g_alarm
            always_ff @(posedge clock or posedge sys_rst) begin
                if (sys_rst) begin
                    alarm_r[i] <= ALARM_RST;
                end else if (reg_wr &&
                        reg_addr == ADDR_ALARM_FIRST + 8'(i)) begin
                    alarm_r[i] <= reg_wdata;
                end
            end
        end
    endgenerate

    // battery-mode period timer on the one-second tick
    assign batt_en = battery_sense_enable_r && !vlow_r;
    assign period_last = battery_sense_rate_r ? FAST_PERIOD_S - 10'h001
                                : SLOW_PERIOD_S - 10'h001;
    assign batt_due = batt_r && batt_en && one_sec_tick &&
        (conv_state_r == CONV_IDLE) && (sec_cnt_r >= period_last);

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            sec_cnt_r <= 10'h000;
        end else if (!batt_r || !batt_en || batt_due) begin
            sec_cnt_r <= 10'h000;
        end else if (one_sec_tick && conv_state_r == CONV_IDLE) begin
            sec_cnt_r <= sec_cnt_r + 10'h001;
        end
    end

    // conversion cycle: two conversions, then average
    assign conv_start = (conv_state_r == CONV_IDLE) &&
        ((tse_start && !batt_r) || batt_due);
    assign conv_end = (conv_state_r == CONV_SECOND) &&
        (conv_cnt_r == 24'h000000);
    assign temp_total = {1'b0, temp_sum_r} + {2'b00, temp_sample};

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            conv_state_r <= CONV_IDLE;
            conv_cnt_r <= 24'h000000;
            temp_sum_r <= 11'h000;
        end else if (batt_r && !batt_en) begin
            conv_state_r <= CONV_IDLE;
            conv_cnt_r <= 24'h000000;
        end else begin
            case (conv_state_r)
                CONV_IDLE: begin
                    if (conv_start) begin
                        conv_state_r <= CONV_FIRST;
                        conv_cnt_r <= 24'(CONV_CYCLES - 1);
                    end
                end
                CONV_FIRST: begin
                    if (conv_cnt_r == 24'h000000) begin
                        conv_state_r <= CONV_SECOND;
                        conv_cnt_r <= 24'(CONV_CYCLES - 1);
                        temp_sum_r <= {1'b0, temp_sample};
                    end else begin
                        conv_cnt_r <= conv_cnt_r - 24'h000001;
                    end
                end
                CONV_SECOND: begin
                    if (conv_end) begin
                        conv_state_r <= CONV_IDLE;
                    end else begin
                        conv_cnt_r <= conv_cnt_r - 24'h000001;
                    end
                end
                default: conv_state_r <= CONV_IDLE;
            endcase
        end
    end

    // results, gain factor and final trims
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            temp_result <= 10'h000;
            comp_coarse_r <= INIT_COARSE_RST;
            comp_fine_r <= INIT_FINE_RST;
            beta_active <= BETA_PRESET;
            coarse_trim_setting <= INIT_COARSE_RST;
            fine_trim_setting <= INIT_FINE_RST;
            sense_active <= 1'b0;
        end else begin
            if (conv_start) begin
                beta_active <= beta_r;
            end
            if (conv_end) begin
                temp_result <= temp_total[10:1];
                comp_coarse_r <= comp_coarse;
                comp_fine_r <= comp_fine;
            end
            coarse_trim_setting <= tse_r ? comp_coarse_r
                                         : init_coarse_r;
            fine_trim_setting <= tse_r ? comp_fine_r : init_fine_r;
            sense_active <= (conv_state_r != CONV_IDLE);
        end
    end

    rtcm_alarm_cmp u_cmp (
        .clock(clock),
        .sys_rst(sys_rst),
        .now(now),
        .alarm(alarm_r),
        .hit(alarm_hit)
    );

    // alarm flag: set beats a clear in the same cycle
    assign flag_clr = (wr_status && !reg_wdata[STAT_ALARM_BIT]) ||
        (rd_status && auto_clr_r);

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            alarm_flag_r <= 1'b0;
        end else if (alarm_hit) begin
            alarm_flag_r <= 1'b1;
        end else if (flag_clr) begin
            alarm_flag_r <= 1'b0;
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            pulse_cnt_r <= 4'h0;
        end else if (alarm_hit && repeat_mode_r) begin
            pulse_cnt_r <= IRQ_PULSE_CYCLES;
        end else if (pulse_cnt_r != 4'h0) begin
            pulse_cnt_r <= pulse_cnt_r - 4'h1;
        end
    end

    assign freq_on = (freq_sel_r != 4'h0);
    assign pull_low = freq_on ? !freq_wave
        : (repeat_mode_r ? (pulse_cnt_r != 4'h0) : alarm_flag_r);

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            irq_pin_oe <= 1'b0;
        end else begin
            irq_pin_oe <= pull_low;
        end
    end

    assign irq_pin_o = 1'b0;

    // read data, monitors with zero upper bits
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            if (reg_addr >= ADDR_ALARM_FIRST &&
                    reg_addr <= ADDR_ALARM_LAST) begin
                reg_rdata <= alarm_r[3'(reg_addr - ADDR_ALARM_FIRST)];
            end else begin
                case (reg_addr)
                    ADDR_BETA: reg_rdata <= {tse_r, battery_sense_enable_r, battery_sense_rate_r, beta_r};
                    ADDR_STATUS: reg_rdata <= {auto_clr_r, alarm_flag_r,
                        6'h00};
                    ADDR_INT_CTRL: reg_rdata <= {repeat_mode_r, 3'h0,
                        freq_sel_r};
                    ADDR_INIT_COARSE: reg_rdata <= {2'h0, init_coarse_r};
                    ADDR_INIT_FINE: reg_rdata <= {3'h0, init_fine_r};
                    ADDR_FINAL_COARSE: reg_rdata <= {2'h0,
                        coarse_trim_setting};
                    ADDR_FINAL_FINE: reg_rdata <= {3'h0,
                        fine_trim_setting};
                    default: reg_rdata <= 8'h00;
                endcase
            end
        end
    end

    sequence s_pulse_low;
        irq_pin_oe [*4] ##1 !irq_pin_oe;
    endsequence

    sequence s_clear_release;
        !alarm_flag_r ##1 !irq_pin_oe;
    endsequence

    chk_coarse_mon_ro: assert property (@(posedge clock) disable iff (sys_rst) reg_rd && reg_addr == ADDR_FINAL_COARSE |=> reg_rdata == {2'h0, $past(coarse_trim_setting)}) else $error("coarse trim monitor read wrong");
    chk_fine_mon_ro: assert property (@(posedge clock) disable iff (sys_rst) reg_rd && reg_addr == ADDR_FINAL_FINE |=> reg_rdata[7:5] == 3'h0 && reg_rdata[4:0] == $past(fine_trim_setting)) else $error("fine trim monitor read wrong");
    chk_flag_on_hit: assert property (@(posedge clock) disable iff (sys_rst) alarm_hit |=> alarm_flag_r) else $error("alarm flag not set on match");
    chk_single_pin_low: assert property (@(posedge clock) disable iff (sys_rst) alarm_flag_r && !freq_on && !repeat_mode_r |=> irq_pin_oe) else $error("pin not low while flag set");
    chk_repeat_pulse: assert property (@(posedge clock) disable iff (sys_rst) alarm_hit && repeat_mode_r && !freq_on && $stable(freq_sel_r) ##1 !alarm_hit && repeat_mode_r && !freq_on |-> ##1 s_pulse_low) else $error("repeat pulse length wrong");
    chk_clear_release: assert property (@(posedge clock) disable iff (sys_rst) wr_status && !reg_wdata[STAT_ALARM_BIT] && !alarm_hit && !repeat_mode_r && !freq_on ##0 (##1 !alarm_hit && !freq_on && !repeat_mode_r) |-> s_clear_release) else $error("clear did not release pin");
    chk_auto_clear: assert property (@(posedge clock) disable iff (sys_rst) rd_status && auto_clr_r && !alarm_hit |=> !alarm_flag_r) else $error("auto clear on read failed");
    chk_low_batt_idle: assert property (@(posedge clock) disable iff (sys_rst) batt_r && (vlow_r || !battery_sense_enable_r) |=> conv_state_r == CONV_IDLE) else $error("battery conversion while disabled");
    chk_beta_apply: assert property (@(posedge clock) disable iff (sys_rst) conv_start |=> beta_active == $past(beta_r) && conv_state_r == CONV_FIRST) else $error("gain factor not taken at cycle start");
    chk_initial_trim: assert property (@(posedge clock) disable iff (sys_rst) !tse_r |=> coarse_trim_setting == $past(init_coarse_r) && fine_trim_setting == $past(init_fine_r)) else $error("initial trims not used");
    chk_period_bound: assert property (@(posedge clock) disable iff (sys_rst) batt_r && batt_en && one_sec_tick && conv_state_r == CONV_IDLE && !wr_beta |=> sec_cnt_r <= period_last) else $error("battery period counter overrun");
    chk_conv_length: assert property (@(posedge clock) disable iff (sys_rst) conv_start && !batt_r |=> conv_cnt_r == 24'(CONV_CYCLES - 1)) else $error("conversion time load wrong");

endmodule
`default_nettype wire
